// File: bldc_pkg.sv
// shared constants and carrier types of the brushless speed control logic
package bldc_pkg;

    // clock rate and power-up hold time
    localparam int CLK_MHZ      = 125;
    localparam int POWERUP_US   = 1000;
    localparam int POWERUP_CYC  = POWERUP_US * CLK_MHZ;
    localparam int PWR_CNT_W    = 20;

    // reference and speed loop figures
    localparam int REF_DIV      = 16;
    localparam int TACH_RATIO   = 8192;
    localparam int SPEED_TARGET = 2 * TACH_RATIO;
    localparam int LOCK_TOL     = SPEED_TARGET / 16;
    localparam int PHASE_W      = $clog2(TACH_RATIO);
    localparam int SPEED_W      = 16;
    localparam int PWM_W        = 8;

    // register byte offsets
    localparam logic [4:0] OFS_CTRL     = 5'h00;
    localparam logic [4:0] OFS_STATUS   = 5'h04;
    localparam logic [4:0] OFS_SPEED    = 5'h08;
    localparam logic [4:0] OFS_PHASE    = 5'h0c;
    localparam logic [4:0] OFS_INT_STAT = 5'h10;
    localparam logic [4:0] OFS_INT_MASK = 5'h14;
    localparam logic [4:0] OFS_DUTY     = 5'h18;

    // control fields and reset values
    localparam int          CTRL_STOP     = 0;
    localparam int          CTRL_STEP_LSB = 8;
    localparam logic [15:0] CTRL_RST      = 16'h0400;
    localparam logic [7:0]  DUTY_RST      = 8'h40;

    // interrupt bit positions
    localparam int INT_LOCK_GAIN = 0;
    localparam int INT_LOCK_LOSS = 1;
    localparam int INT_LIMIT     = 2;
    localparam int INT_SPEED     = 3;
    localparam int INT_W         = 4;

    // synchronised pin vector: hall plus, hall minus, tach, run/stop, dir, limit
    localparam int          PIN_W   = 11;
    localparam int          PIN_TP  = 6;
    localparam int          PIN_TN  = 7;
    localparam int          PIN_SS  = 8;
    localparam int          PIN_DIR = 9;
    localparam int          PIN_LIM = 10;
    localparam logic [10:0] PIN_RST = 11'h300;

    typedef enum logic [2:0] {
        ST_PWRUP = 3'b001,
        ST_STOP  = 3'b010,
        ST_RUN   = 3'b100
    } fsm_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } avReq_t;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } avRsp_t;

    typedef struct packed {
        logic [2:0] upper;
        logic [2:0] lower;
    } drive_t;

    typedef struct packed {
        fsm_t                   fsm;
        logic [PWR_CNT_W-1:0]   pwrCnt;
        logic [7:0]             refDiv;
        logic [PHASE_W-1:0]     refPhase;
        logic [PHASE_W-1:0]     phaseErr;
        logic [SPEED_W-1:0]     periodCnt;
        logic [SPEED_W-1:0]     speedCnt;
        logic                   halfSel;
        logic                   tach;
        logic                   accel;
        logic                   lockN;
        logic                   limitHit;
        logic                   powerSave;
        logic                   irq;
        logic [PWM_W-1:0]       duty;
        logic [PWM_W-1:0]       pwmCnt;
        logic [15:0]            ctrl;
        logic [INT_W-1:0]       intStat;
        logic [INT_W-1:0]       intMask;
        drive_t                 drive;
        avRsp_t                 rsp;
    } state_t;

    localparam state_t STATE_RST = '{
        fsm: ST_PWRUP, pwrCnt: '0, refDiv: '0, refPhase: '0, phaseErr: '0,
        periodCnt: '0, speedCnt: '0, halfSel: 1'b0, tach: 1'b0, accel: 1'b0,
        lockN: 1'b1, limitHit: 1'b0, powerSave: 1'b1, irq: 1'b0,
        duty: DUTY_RST, pwmCnt: '0, ctrl: CTRL_RST, intStat: '0, intMask: '0,
        drive: '0, rsp: '{waitrequest: 1'b1, readdata: '0}
    };

endpackage

// File: sync_stage.sv
// two flip-flop synchroniser with a chosen reset value
`timescale 1ns/10ps
`default_nettype none

module sync_stage #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstN,
    // data
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule
`default_nettype wire

// File: bldc_speed_control_logic.sv
// control logic of a three-phase brushless motor driver with speed loop
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - The tachometer inputs are squared by a comparator with hysteresis into the speed pulse.
// - After power-up the logic is held in the power-up state for a charge time before it is released.
// - Run/stop low asks to run, high asks to stop, and an open input reads as stop.
// - Direction low asks forward, high asks reverse, and an open input reads as reverse.
// - Each position sensor reads high when its plus input exceeds its minus input, else low.
// - The discriminator counts reference ticks and gives a new speed result every two periods.
// - The phase loop gives a new phase error on every tachometer period.
// - The target tachometer frequency is the reference frequency divided by 8192.
// - Drive power is set by the on-time duty of the output, switches fully on while on.
// - Chopping acts on the lower switch only; the conducting upper switch stays on.
// - When the peak current reaches the limit threshold the on-time is cut.
// - In stop the block enters power save and removes drive from the motor.
// - The lock indicator is low while speed is within 6.25 percent of target, else high.
// - The discriminator output is high to accelerate and low to decelerate.
module bldc_speed_control_logic #(
    parameter int POWERUP_CYCLES = bldc_pkg::POWERUP_CYC,
    parameter int REF_DIV_P      = bldc_pkg::REF_DIV
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // rotor position sensors
    input  wire logic             pos_sensor1_pos,
    input  wire logic             pos_sensor1_neg,
    input  wire logic             pos_sensor2_pos,
    input  wire logic             pos_sensor2_neg,
    input  wire logic             pos_sensor3_pos,
    input  wire logic             pos_sensor3_neg,
    // tachometer amplifier comparator inputs
    input  wire logic             tach_amp_pos_in,
    input  wire logic             tach_amp_neg_in,
    // host selections and current sense
    input  wire logic             runStopN,
    input  wire logic             dirRev,
    input  wire logic             currentLimitHit,
    // register bus
    input  wire bldc_pkg::avReq_t avReq,
    output var  bldc_pkg::avRsp_t avRsp,
    // motor side and status pins
    output var  bldc_pkg::drive_t drive,
    output var  logic             tach_pulse,
    output var  logic             lock_indicator,
    output var  logic             discOut,
    output var  logic             powerSave,
    output var  logic             irq
);
    import bldc_pkg::*;

    // elaboration checks on the parameters
    if (POWERUP_CYCLES < 1 || POWERUP_CYCLES >= 2 ** PWR_CNT_W) begin : g_badPwr
        $error("POWERUP_CYCLES out of range");
    end
    if (REF_DIV_P < 2 || REF_DIV_P > 256) begin : g_badDiv
        $error("REF_DIV_P out of range");
    end

    localparam logic [PWR_CNT_W-1:0] PWR_LAST = PWR_CNT_W'(POWERUP_CYCLES - 1);
    localparam logic [7:0]           DIV_LAST = 8'(REF_DIV_P - 1);

    state_t            s_r;
    state_t            s_nxt;
    logic              rstSyncN;
    logic [PIN_W-1:0]  pinS;
    logic [2:0]        hallLvl;
    logic              tachRise;
    logic              speedEvt;
    logic              refTick;
    logic              stopReq;
    logic              pwmOn;
    logic              busReq;
    logic              busAcc;
    logic [7:0]        step;
    logic [INT_W-1:0]  evt;
    logic [31:0]       rdData;
    drive_t            cm;

    // speed within the lock window around the two-period target
    function automatic logic inWindow(input logic [SPEED_W-1:0] cnt);
        return (32'(cnt) + 32'(LOCK_TOL) >= 32'(SPEED_TARGET)) &&
               (32'(cnt) <= 32'(SPEED_TARGET) + 32'(LOCK_TOL));
    endfunction

    // six-step table, reverse swaps the upper and lower selections
    function automatic drive_t commutate(input logic [2:0] h, input logic rev);
        drive_t d;
        d = '0;
        case (h)
            3'h1: d = '{upper: 3'h1, lower: 3'h2};
            3'h3: d = '{upper: 3'h1, lower: 3'h4};
            3'h2: d = '{upper: 3'h2, lower: 3'h4};
            3'h6: d = '{upper: 3'h2, lower: 3'h1};
            3'h4: d = '{upper: 3'h4, lower: 3'h1};
            3'h5: d = '{upper: 3'h4, lower: 3'h2};
            default: d = '0;
        endcase
        if (rev) begin
            d = '{upper: d.lower, lower: d.upper};
        end
        return d;
    endfunction

    // byte-lane write merge
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    // power-up hold
    // the logic stays in the power-up state until the charge count runs out
    sync_stage #(
        .WIDTH   (1),
        .RST_VAL (1'b0)
    ) u_rstSync (
        .clk  (mclk),
        .rstN (rst_n),
        .d    (1'b1),
        .q    (rstSyncN)
    );

    // open pins read as stop and reverse through the reset values
    sync_stage #(
        .WIDTH   (PIN_W),
        .RST_VAL (PIN_RST)
    ) u_pinSync (
        .clk  (mclk),
        .rstN (rstSyncN),
        .d    ({currentLimitHit, dirRev, runStopN, tach_amp_neg_in, tach_amp_pos_in,
                pos_sensor3_neg, pos_sensor2_neg, pos_sensor1_neg,
                pos_sensor3_pos, pos_sensor2_pos, pos_sensor1_pos}),
        .q    (pinS)
    );

    for (genvar i = 0; i < 3; i++) begin : g_hall
        assign hallLvl[i] = pinS[i] & ~pinS[3+i];
    end

    // next-state logic for the whole block
    always_comb begin
        s_nxt    = s_r;
        stopReq  = pinS[PIN_SS] | s_r.ctrl[CTRL_STOP];
        step     = s_r.ctrl[CTRL_STEP_LSB +: 8];
        busReq   = avReq.read | avReq.write;
        busAcc   = busReq & ~s_r.rsp.waitrequest;
        rdData   = '0;
        evt      = '0;

        // hysteresis: equal inputs keep the last level, so noise cannot chatter
        if (pinS[PIN_TP] && !pinS[PIN_TN]) begin
            s_nxt.tach = 1'b1;
        end else if (!pinS[PIN_TP] && pinS[PIN_TN]) begin
            s_nxt.tach = 1'b0;
        end
        tachRise = s_nxt.tach & ~s_r.tach;
        speedEvt = tachRise & s_r.halfSel;

        // reference phase wraps every 8192 ticks, one target period
        refTick      = (s_r.refDiv == DIV_LAST);
        s_nxt.refDiv = refTick ? 8'h00 : s_r.refDiv + 8'h01;
        if (refTick) begin
            s_nxt.refPhase = s_r.refPhase + PHASE_W'(1);
        end

        // two-period count, saturating so a stall cannot wrap into lock
        if (refTick && s_r.periodCnt != '1) begin
            s_nxt.periodCnt = s_r.periodCnt + SPEED_W'(1);
        end
        if (tachRise) begin
            s_nxt.phaseErr = s_r.refPhase;
            s_nxt.halfSel  = ~s_r.halfSel;
            if (s_r.halfSel) begin
                s_nxt.speedCnt  = s_r.periodCnt;
                // this cycle's tick opens the next window, so no tick is lost
                s_nxt.periodCnt = SPEED_W'(refTick);
                // slow motor gives a long count, ask to accelerate
                s_nxt.accel     = 32'(s_r.periodCnt) > 32'(SPEED_TARGET);
                s_nxt.lockN     = ~inWindow(s_r.periodCnt);
            end
        end else if (s_r.periodCnt == '1) begin
            s_nxt.lockN = 1'b1;
            s_nxt.accel = 1'b1;
        end

        // duty steps by the speed result, fine trim by phase sign
        if (speedEvt) begin
            if (s_nxt.accel) begin
                s_nxt.duty = (s_r.duty > ~step) ? '1 : s_r.duty + step;
            end else begin
                s_nxt.duty = (s_r.duty < step) ? '0 : s_r.duty - step;
            end
        end else if (tachRise) begin
            if (s_r.refPhase[PHASE_W-1] && s_r.duty != '1) begin
                s_nxt.duty = s_r.duty + PWM_W'(1);
            end else if (!s_r.refPhase[PHASE_W-1] && s_r.duty != '0) begin
                s_nxt.duty = s_r.duty - PWM_W'(1);
            end
        end

        // current limit cuts the rest of this pwm period; set wins over re-arm
        s_nxt.pwmCnt = s_r.pwmCnt + PWM_W'(1);
        if (&s_r.pwmCnt) begin
            s_nxt.limitHit = 1'b0;
        end
        if (pinS[PIN_LIM]) begin
            s_nxt.limitHit = 1'b1;
        end

        // operating state machine
        case (s_r.fsm)
            ST_PWRUP: begin
                if (s_r.pwrCnt == PWR_LAST) begin
                    s_nxt.fsm = ST_STOP;
                end else begin
                    s_nxt.pwrCnt = s_r.pwrCnt + PWR_CNT_W'(1);
                end
            end
            ST_STOP: begin
                if (!stopReq) begin
                    s_nxt.fsm = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stopReq) begin
                    s_nxt.fsm = ST_STOP;
                end
            end
            default: s_nxt.fsm = ST_PWRUP;
        endcase

        // power save freezes the loop and restarts it from a known duty
        s_nxt.powerSave = (s_nxt.fsm != ST_RUN);
        if (s_nxt.powerSave) begin
            s_nxt.periodCnt = '0;
            s_nxt.halfSel   = 1'b0;
            s_nxt.lockN     = 1'b1;
            s_nxt.accel     = 1'b0;
            s_nxt.duty      = DUTY_RST;
        end

        cm    = commutate(hallLvl, pinS[PIN_DIR]);
        pwmOn = (s_nxt.pwmCnt < s_nxt.duty) & ~s_nxt.limitHit;
        // upper steady, only the lower switch is chopped
        s_nxt.drive.upper = s_nxt.powerSave ? 3'h0 : cm.upper;
        s_nxt.drive.lower = (s_nxt.powerSave || !pwmOn) ? 3'h0 : cm.lower;

        // events for the interrupt status
        evt[INT_LOCK_GAIN] = s_r.lockN & ~s_nxt.lockN;
        evt[INT_LOCK_LOSS] = ~s_r.lockN & s_nxt.lockN;
        evt[INT_LIMIT]     = pinS[PIN_LIM] & ~s_r.limitHit;
        evt[INT_SPEED]     = speedEvt;

        // read mux; unmapped addresses read zero
        case (avReq.address)
            OFS_CTRL:     rdData = {16'h0000, s_r.ctrl};
            OFS_STATUS:   rdData = {21'h000000, s_r.drive, s_r.limitHit, s_r.fsm == ST_RUN,
                                    pinS[PIN_DIR], s_r.accel, ~s_r.lockN};
            OFS_SPEED:    rdData = {16'h0000, s_r.speedCnt};
            OFS_PHASE:    rdData = {19'h00000, s_r.phaseErr};
            OFS_INT_STAT: rdData = {28'h0000000, s_r.intStat};
            OFS_INT_MASK: rdData = {28'h0000000, s_r.intMask};
            OFS_DUTY:     rdData = {24'h000000, s_r.duty};
            default:      rdData = '0;
        endcase

        // one wait cycle: data is captured when the request is first seen
        s_nxt.rsp.waitrequest = ~(busReq & s_r.rsp.waitrequest);
        s_nxt.intStat = s_r.intStat;
        if (busReq && s_r.rsp.waitrequest && avReq.read) begin
            s_nxt.rsp.readdata = rdData;
            // read clears only what was captured
            if (avReq.address == OFS_INT_STAT) begin
                s_nxt.intStat = '0;
            end
        end
        // an event in the clearing cycle is kept
        s_nxt.intStat = s_nxt.intStat | evt;

        // writes land at the edge where waitrequest is seen low
        if (busAcc && avReq.write) begin
            case (avReq.address)
                OFS_CTRL: begin
                    s_nxt.ctrl = 16'(wmerge({16'h0000, s_r.ctrl}, avReq.writedata,
                                            avReq.byteenable));
                end
                OFS_INT_MASK: begin
                    s_nxt.intMask = INT_W'(wmerge({28'h0000000, s_r.intMask},
                                                  avReq.writedata, avReq.byteenable));
                end
                default: s_nxt.intMask = s_r.intMask;
            endcase
        end

        s_nxt.irq = |(s_nxt.intStat & s_nxt.intMask);
    end

    // the single state register
    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops; lock pin is low while in lock
    assign avRsp          = s_r.rsp;
    assign drive          = s_r.drive;
    assign tach_pulse     = s_r.tach;
    assign lock_indicator = s_r.lockN;
    assign discOut        = s_r.accel;
    assign powerSave      = s_r.powerSave;
    assign irq            = s_r.irq;

    // checks on the block's own behaviour
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstSyncN);

    a_tach_square: assert property (
        pinS[PIN_TP] && !pinS[PIN_TN] |=> tach_pulse)
        else $error("tach pulse not squared high");
    a_powerup_quiet: assert property (
        s_r.fsm == ST_PWRUP |-> drive == '0 && lock_indicator)
        else $error("drive active during power-up hold");
    a_stop_request: assert property (
        pinS[PIN_SS] && s_r.fsm == ST_RUN |=> s_r.fsm == ST_STOP)
        else $error("stop request not honoured");
    a_dir_table: assert property (
        s_r.fsm == ST_RUN ##1 s_r.fsm == ST_RUN
        |-> drive.upper == $past(cm.upper))
        else $error("upper switch does not follow sensors and direction");
    a_speed_pair: assert property (
        tachRise && s_r.halfSel && s_r.fsm == ST_RUN && !stopReq
        |=> s_r.speedCnt == $past(s_r.periodCnt))
        else $error("speed result not taken at second period");
    a_speed_hold: assert property (
        tachRise && !s_r.halfSel |=> $stable(s_r.speedCnt))
        else $error("speed result changed after one period");
    a_phase_each: assert property (
        tachRise |=> s_r.phaseErr == $past(s_r.refPhase))
        else $error("phase error not updated on period");
    a_ref_wrap: assert property (
        refTick && s_r.refPhase == '1 |=> s_r.refPhase == '0)
        else $error("reference phase does not wrap at 8192");
    a_pwm_gate: assert property (
        s_r.pwmCnt >= s_r.duty |-> drive.lower == 3'h0)
        else $error("lower switch on outside duty");
    a_upper_steady: assert property (
        s_r.fsm == ST_RUN && $stable(hallLvl) && $stable(pinS[PIN_DIR]) && !stopReq
        |=> $stable(drive.upper))
        else $error("upper switch chopped");
    a_limit_cut: assert property (
        s_r.limitHit |-> drive.lower == 3'h0)
        else $error("lower switch on while current limited");
    a_stop_save: assert property (
        s_r.fsm == ST_STOP |-> powerSave && drive == '0)
        else $error("stop without power save");
    a_lock_window: assert property (
        speedEvt && inWindow(s_r.periodCnt) && s_nxt.fsm == ST_RUN |=> !lock_indicator)
        else $error("lock not shown inside window");
    a_disc_sign: assert property (
        speedEvt && s_nxt.fsm == ST_RUN
        |=> discOut == ($past(32'(s_r.periodCnt)) > 32'(SPEED_TARGET)))
        else $error("discriminator sign wrong");

    c_lock_reached: cover property (s_r.lockN ##1 !s_r.lockN);
    c_limit_hit: cover property (s_r.fsm == ST_RUN ##1 s_r.limitHit);
    c_reverse_run: cover property (s_r.fsm == ST_RUN && pinS[PIN_DIR] && drive.upper != 3'h0);
    c_int_read: cover property (irq ##[1:20] avReq.read && avReq.address == OFS_INT_STAT);

endmodule
`default_nettype wire

// File: motor_model.sv
// behavioural motor: tach winding pair and three position sensors
`timescale 1ns/10ps
`default_nettype none

module motor_model (
    // clock
    input  wire logic        mclk,
    // speed and rotor control
    input  wire logic        spin,
    input  wire logic [15:0] period,
    input  wire logic [2:0]  hall,
    // sensor pins
    output var  logic        tachPos,
    output var  logic        tachNeg,
    output var  logic [2:0]  hallPos,
    output var  logic [2:0]  hallNeg
);
    logic [15:0] cnt = '0;
    logic [15:0] per = 16'h2000;

    // period taken only at a rising edge so a speed change lands whole
    always @(posedge mclk) begin
        if (!spin)
            cnt <= '0;
        else
            cnt <= (cnt + 16'h1 >= per) ? '0 : cnt + 16'h1;
        if (cnt == '0)
            per <= period;
    end

    // complementary tach pair
    // winding stands low while the rotor is still
    always_comb begin
        tachPos = spin && (cnt < per / 2);
        tachNeg = !tachPos;
        hallPos = hall;
        hallNeg = ~hall;
    end
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench of the brushless speed control logic
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import bldc_pkg::*;
    logic mclk, rst_n, runStopN, dirRev, limHit, spin, tp, tn;
    logic [15:0] period;
    logic [2:0] hall, hp, hn;
    avReq_t avReq;
    avRsp_t avRsp;
    drive_t drive;
    logic tachQ, lockQ, discQ, saveQ, irqQ;
    int errCount = 0;
    int checkCount = 0;
    logic [2:0] codes [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    logic [2:0] upFwd [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
    logic [2:0] upRev [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};

    bldc_speed_control_logic #(.POWERUP_CYCLES(20), .REF_DIV_P(2)) dut (
        .mclk(mclk), .rst_n(rst_n),
        .pos_sensor1_pos(hp[0]), .pos_sensor1_neg(hn[0]),
        .pos_sensor2_pos(hp[1]), .pos_sensor2_neg(hn[1]),
        .pos_sensor3_pos(hp[2]), .pos_sensor3_neg(hn[2]),
        .tach_amp_pos_in(tp), .tach_amp_neg_in(tn), .runStopN(runStopN),
        .dirRev(dirRev), .currentLimitHit(limHit), .avReq(avReq), .avRsp(avRsp),
        .drive(drive), .tach_pulse(tachQ), .lock_indicator(lockQ),
        .discOut(discQ), .powerSave(saveQ), .irq(irqQ));

    motor_model motor (.mclk(mclk), .spin(spin), .period(period), .hall(hall),
        .tachPos(tp), .tachNeg(tn), .hallPos(hp), .hallNeg(hn));

    // reference derived from the bench clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checkCount++;
        if (g !== e) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // one access; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge mclk);
        avReq <= '{read: !wr, write: wr, address: a, byteenable: 4'hf, writedata: wd};
        // only the watchdog ends a wait that never gets its answer
        do begin
            @(posedge mclk);
        end while (avRsp.waitrequest !== 1'b0);
        rd = avRsp.readdata;
        avReq <= '0;
    endtask

    task automatic rdChk(input string n, input logic [4:0] a, input logic [31:0] m,
                         input logic [31:0] e);
        logic [31:0] d;
        bus(1'b0, a, '0, d);
        chk(n, e, d & m);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    // tach pulse follows the squared winding level
    task automatic tachChk(input logic v);
        while (tp !== v) begin
            @(posedge mclk);
        end
        repeat (5) @(posedge mclk);
        chk("tach_pulse", v, tachQ);
    endtask

    task automatic chopCount(output int on, output int chg);
        logic [2:0] up0;
        on = 0;
        chg = 0;
        up0 = drive.upper;
        repeat (256) begin
            @(posedge mclk);
            on += (drive.lower !== 3'h0);
            chg += (drive.upper !== up0);
        end
    endtask

    task automatic printVerdict();
        $display("checks %0d errors %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog sized a little above the longest motor sequence
    initial begin
        repeat (95000) @(posedge mclk);
        errCount++;
        printVerdict();
    end

    initial begin
        int on, chg;
        {rst_n, limHit, spin, avReq} <= '0;
        runStopN <= 1'b1;
        dirRev <= 1'b1;
        hall <= 3'h1;
        period <= 16'h2000;
        repeat (2) @(posedge mclk);
        chk("lock reset", 1, lockQ);
        chk("drive reset", 0, drive);
        rst_n <= 1'b1;
        repeat (40) @(posedge mclk);
        rdChk("ctrl", OFS_CTRL, 32'hffff, CTRL_RST);
        rdChk("unmapped", 5'h1c, 32'hffffffff, 0);
        wr(OFS_DUTY, 32'h12);
        rdChk("duty ro", OFS_DUTY, 32'hff, DUTY_RST);
        wr(OFS_INT_MASK, 32'hc);
        rdChk("mask", OFS_INT_MASK, 32'hf, 32'hc);
        chk("stop save", 1, saveQ);
        chk("stop drive", 0, drive);
        rdChk("status rev", OFS_STATUS, 32'hc, 32'h4);
        runStopN <= 1'b0;
        dirRev <= 1'b0;
        spin <= 1'b1;
        repeat (10) @(posedge mclk);
        chk("run save", 0, saveQ);
        for (int i = 0; i < 12; i++) begin
            dirRev <= (i >= 6);
            hall <= codes[i % 6];
            repeat (8) @(posedge mclk);
            chk("upper", (i < 6) ? upFwd[i] : upRev[i - 6], drive.upper);
        end
        dirRev <= 1'b0;
        repeat (10) @(posedge mclk);
        chopCount(on, chg);
        chk("upper steady", 0, chg);
        chk("lower chopped", 1, on > 0 && on < 256);
        limHit <= 1'b1;
        repeat (300) @(posedge mclk);
        chopCount(on, chg);
        chk("limit off", 0, on);
        rdChk("limit status", OFS_STATUS, 32'h10, 32'h10);
        rdChk("limit event", OFS_INT_STAT, 32'h4, 32'h4);
        limHit <= 1'b0;
        tachChk(1'b1);
        tachChk(1'b0);
        repeat (24000) @(posedge mclk);
        chk("fast disc", 0, discQ);
        chk("fast unlock", 1, lockQ);
        period <= 16'h4000;
        // long enough for a full pair of target-rate periods to be counted
        repeat (54500) @(posedge mclk);
        rdChk("speed", OFS_SPEED, 32'hffff, 2 * TACH_RATIO);
        chk("locked", 0, lockQ);
        chk("irq", 1, irqQ);
        rdChk("events", OFS_INT_STAT, 32'h9, 32'h9);
        rdChk("cleared", OFS_INT_STAT, 32'hf, 0);
        repeat (3) @(posedge mclk);
        chk("irq clear", 0, irqQ);
        printVerdict();
    end
endmodule
`default_nettype wire
